/* wsr_cfg.svh */
/*
 Constants for the warning status registers: parameter addresses, bit
 positions, reset values and masks. Assumes the includer needs only
 macros; holds no logic.
*/
`ifndef WSR_CFG_SVH
`define WSR_CFG_SVH

`define WSR_ADDR_ACTIVE   16'h1c16
`define WSR_ADDR_LATCHED  16'h1c18

`define WSR_BIT_GENERAL   0
`define WSR_BIT_STAGE_TMP 1
`define WSR_BIT_MOTOR_TMP 2
`define WSR_BIT_STAGE_I2T 4
`define WSR_BIT_MOTOR_I2T 5
`define WSR_BIT_CAN       7
`define WSR_BIT_ENCODER   8
`define WSR_BIT_RS485     9
`define WSR_BIT_TORQUE    10
`define WSR_BIT_UNDERVOLT 11
`define WSR_BIT_FIELDBUS2 12
`define WSR_BIT_POS_BUSY  13
`define WSR_BIT_ETHERNET  14

`define WSR_WORD_RESET    16'h0000
`define WSR_RSVD_MASK     16'h8048
`define WSR_SELF_CLR_MASK 16'h2c00

`endif

/* wsr_pkg.sv */
/*
 Types shared by the warning status registers. Assumes wsr_cfg.svh
 supplies the numeric constants.
*/
package wsr_pkg;
    typedef logic [15:0] wsr_word_t;
    typedef logic [15:0] wsr_addr_t;
endpackage

/* wsr_top.sv */
/*
 Warning status registers: live and latched warning words read as
 parameters. Assumes warning sources are logic on this clock, except
 the two torque off inputs, which are pins and are synchronised here.
*/
`timescale 1ns/1ns
`include "wsr_cfg.svh"

module wsr_top (
    input  wire logic               clock,
    input  wire logic               sys_rst,
    input  wire logic               general_warn,
    input  wire logic               stage_temp_warn,
    input  wire logic               motor_temp_warn,
    input  wire logic               stage_overload_warn,
    input  wire logic               motor_overload_warn,
    input  wire logic               can_warn,
    input  wire logic               encoder_warn,
    input  wire logic               rs485_warn,
    input  wire logic               torque_off_input_a,
    input  wire logic               torque_off_input_b,
    input  wire logic               undervolt_warn,
    input  wire logic               fieldbus2_warn,
    input  wire logic               pos_capture_busy,
    input  wire logic               ethernet_warn,
    input  wire logic               fault_clear_command,
    input  wire logic               param_rd_req,
    input  wire wsr_pkg::wsr_addr_t param_rd_addr,
    output wsr_pkg::wsr_word_t      param_rd_data,
    output logic                    param_rd_ack,
    output logic                    param_rd_err,
    output wsr_pkg::wsr_word_t      active_warning_word,
    output wsr_pkg::wsr_word_t      latched_warning_word
);

    wsr_pkg::wsr_word_t active_reg;
    wsr_pkg::wsr_word_t active_next;
    wsr_pkg::wsr_word_t latched_reg;
    wsr_pkg::wsr_word_t latched_next;
    wsr_pkg::wsr_word_t rd_data_reg;
    logic               rd_ack_reg;
    logic               rd_err_reg;
    logic [1:0]         torque_off_input_a_sync_reg;
    logic [1:0]         torque_off_input_b_sync_reg;

    // Torque off pins are asynchronous; first stage feeds only the second
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            torque_off_input_a_sync_reg <= 2'h0;
            torque_off_input_b_sync_reg <= 2'h0;
        end else begin
            torque_off_input_a_sync_reg <= {torque_off_input_a_sync_reg[0], torque_off_input_a};
            torque_off_input_b_sync_reg <= {torque_off_input_b_sync_reg[0], torque_off_input_b};
        end
    end

    // Map each live condition to its bit; unassigned bits stay zero
    always_comb begin
        active_next = `WSR_WORD_RESET;
        active_next[`WSR_BIT_GENERAL]   = general_warn;
        active_next[`WSR_BIT_STAGE_TMP] = stage_temp_warn;
        active_next[`WSR_BIT_MOTOR_TMP] = motor_temp_warn;
        active_next[`WSR_BIT_STAGE_I2T] = stage_overload_warn;
        active_next[`WSR_BIT_MOTOR_I2T] = motor_overload_warn;
        active_next[`WSR_BIT_CAN]       = can_warn;
        active_next[`WSR_BIT_ENCODER]   = encoder_warn;
        active_next[`WSR_BIT_RS485]     = rs485_warn;
        active_next[`WSR_BIT_TORQUE]    = torque_off_input_a_sync_reg[1]
                                        | torque_off_input_b_sync_reg[1];
        active_next[`WSR_BIT_UNDERVOLT] = undervolt_warn;
        active_next[`WSR_BIT_FIELDBUS2] = fieldbus2_warn;
        active_next[`WSR_BIT_POS_BUSY]  = pos_capture_busy;
        active_next[`WSR_BIT_ETHERNET]  = ethernet_warn;
        active_next = active_next & ~`WSR_RSVD_MASK;
    end

    // Latch: held bits survive unless cleared, self-clearing bits are
    // dropped; new activity is ORed last so a set beats a same-cycle clear
    always_comb begin
        latched_next = latched_reg & ~`WSR_SELF_CLR_MASK;
        if (fault_clear_command) begin
            latched_next = `WSR_WORD_RESET;
        end
        latched_next = (latched_next | active_next)
                     & ~`WSR_RSVD_MASK;
    end

    // Both words register on the same edge so every live bit shows in the latched word in the same cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            active_reg  <= `WSR_WORD_RESET;
            latched_reg <= `WSR_WORD_RESET;
        end else begin
            active_reg  <= active_next;
            latched_reg <= latched_next;
        end
    end

    // Parameter read: answer one cycle after the request
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rd_data_reg <= `WSR_WORD_RESET;
            rd_ack_reg  <= 1'b0;
            rd_err_reg  <= 1'b0;
        end else begin
            rd_ack_reg  <= param_rd_req;
            rd_err_reg  <= 1'b0;
            rd_data_reg <= `WSR_WORD_RESET;
            if (param_rd_req) begin
                if (param_rd_addr == `WSR_ADDR_ACTIVE) begin
                    rd_data_reg <= active_reg;
                end else if (param_rd_addr == `WSR_ADDR_LATCHED) begin
                    rd_data_reg <= latched_reg;
                end else begin
                    rd_err_reg  <= 1'b1;   // Unknown address, data zero
                end
            end
        end
    end

    assign param_rd_data        = rd_data_reg;
    assign param_rd_ack         = rd_ack_reg;
    assign param_rd_err         = rd_err_reg;
    assign active_warning_word  = active_reg;
    assign latched_warning_word = latched_reg;

    default clocking wsr_cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    AST_RD_ACTIVE: assert property (
        param_rd_req && param_rd_addr == `WSR_ADDR_ACTIVE
        |=> param_rd_ack && !param_rd_err
            && param_rd_data == $past(active_warning_word))
        else $error("Active word read returned wrong data");

    AST_RD_LATCHED: assert property (
        param_rd_req && param_rd_addr == `WSR_ADDR_LATCHED
        |=> param_rd_ack && param_rd_data == $past(latched_warning_word))
        else $error("Latched word read returned wrong data");

    AST_LATCH_HOLD: assert property (
        !fault_clear_command
        |=> (($past(latched_warning_word) & ~latched_warning_word)
             & ~`WSR_SELF_CLR_MASK) == 16'h0)
        else $error("Held warning bit dropped without fault clear");

    AST_CLEAR: assert property (
        fault_clear_command && active_next == 16'h0
        |=> latched_warning_word == 16'h0)
        else $error("Fault clear left latched bits set");

    AST_SELF_CLR: assert property (
        (latched_warning_word & `WSR_SELF_CLR_MASK)
        == (active_warning_word & `WSR_SELF_CLR_MASK))
        else $error("Self-clearing bit not following live state");

    AST_GENERAL: assert property (
        general_warn |=> active_warning_word[`WSR_BIT_GENERAL])
        else $error("General warning bit not set");

    AST_TEMP: assert property (
        ##1 active_warning_word[`WSR_BIT_MOTOR_TMP] == $past(motor_temp_warn)
        && active_warning_word[`WSR_BIT_STAGE_TMP] == $past(stage_temp_warn))
        else $error("Temperature bits wrong");

    AST_OVERLOAD: assert property (
        stage_overload_warn && !motor_overload_warn
        |=> active_warning_word[5:4] == 2'h1)
        else $error("Overload bits wrong");

    AST_COMMS: assert property (
        ##1 active_warning_word[9:7]
            == {$past(rs485_warn), $past(encoder_warn), $past(can_warn)})
        else $error("Communication warning bits wrong");

    // Two synchroniser stages plus the word register: the bit shows on the
    // third edge, counting the edge that first samples the pin high
    AST_TORQUE: assert property (
        (torque_off_input_a || torque_off_input_b) [*3]
        |=> active_warning_word[`WSR_BIT_TORQUE])
        else $error("Torque off bit not set three cycles after pin");

    AST_POS_BUSY: assert property (
        $fell(pos_capture_busy) |=> !latched_warning_word[`WSR_BIT_POS_BUSY])
        else $error("Position busy bit stayed latched");

    AST_RSVD: assert property (
        ((active_warning_word | latched_warning_word) & `WSR_RSVD_MASK)
        == 16'h0)
        else $error("Reserved bit set");

    AST_SAME_CYCLE: assert property (
        (active_warning_word & ~latched_warning_word) == 16'h0)
        else $error("Active bit not mirrored in latched word");

    // Unknown addresses answer with an error pulse and zero data, so a
    // master never mistakes a typo for an all-clear warning word
    AST_RD_UNKNOWN: assert property (
        param_rd_req && param_rd_addr != `WSR_ADDR_ACTIVE
        && param_rd_addr != `WSR_ADDR_LATCHED
        |=> param_rd_ack && param_rd_err && param_rd_data == 16'h0000)
        else $error("Unknown parameter address not refused");

    AST_RD_IDLE: assert property (
        !param_rd_req |=> !param_rd_ack && !param_rd_err
            && param_rd_data == 16'h0000)
        else $error("Read answer without a request");

    AST_CLEAR_LIVE: assert property (
        fault_clear_command |=> latched_warning_word == active_warning_word)
        else $error("Fault clear did not leave only live warnings");

    AST_OVERLOAD_MOTOR: assert property (
        motor_overload_warn && !stage_overload_warn
        |=> active_warning_word[5:4] == 2'h2)
        else $error("Motor overload bit wrong");

    AST_UNDERVOLT: assert property (
        ##1 active_warning_word[`WSR_BIT_UNDERVOLT] == $past(undervolt_warn))
        else $error("Undervoltage bit wrong");

    AST_NET: assert property (
        ##1 (active_warning_word[`WSR_BIT_FIELDBUS2] == $past(fieldbus2_warn)
        && active_warning_word[`WSR_BIT_POS_BUSY] == $past(pos_capture_busy)
        && active_warning_word[`WSR_BIT_ETHERNET] == $past(ethernet_warn)))
        else $error("Fieldbus, position or Ethernet bit wrong");

endmodule

/* wsr_master.sv */
/*
 Model of the fieldbus master that reads the warning words as
 parameters. Assumes the read port of wsr_top on the same clock.
*/
`timescale 1ns/1ns

module wsr_master (
    input  wire logic               clock,
    output logic                    param_rd_req,
    output wsr_pkg::wsr_addr_t      param_rd_addr,
    input  wire wsr_pkg::wsr_word_t param_rd_data,
    input  wire logic               param_rd_ack,
    input  wire logic               param_rd_err
);
    // Idle bus at time zero
    initial begin
        param_rd_req  = 1'b0;
        param_rd_addr = 16'h0000;
    end

    // One read; the address is inverted once released, never left stale
    task automatic rd(input wsr_pkg::wsr_addr_t a,
                      output wsr_pkg::wsr_word_t d, output logic e);
        int k;
        d = 16'hffff;
        e = 1'b1;
        @(posedge clock);
        param_rd_req  <= 1'b1;
        param_rd_addr <= a;
        @(posedge clock);
        param_rd_req  <= 1'b0;  // Single-cycle strobe; address held to ack
        for (k = 0; k < 4; k++) begin
            @(posedge clock);
            if (param_rd_ack === 1'b1) begin
                d = param_rd_data;
                e = param_rd_err;
                break;
            end
        end
        param_rd_addr <= ~a;
    endtask
endmodule

/* warning_status_registers_tb.sv */
/*
 Self-checking bench for the warning status registers. Assumes the
 wsr_master model for parameter reads and the constants of wsr_cfg.svh.
*/
`timescale 1ns/1ns
`include "wsr_cfg.svh"

module warning_status_registers_tb;
    logic               clock, sys_rst, fclr, tob, req, ack, err;
    logic [15:0]        src;
    wsr_pkg::wsr_addr_t addr;
    wsr_pkg::wsr_word_t rdata, act, lat, held, expw;
    int                 n_fail, n_compared, i;

    wsr_top DUT (
        .clock(clock), .sys_rst(sys_rst), .general_warn(src[0]),
        .stage_temp_warn(src[1]), .motor_temp_warn(src[2]),
        .stage_overload_warn(src[4]), .motor_overload_warn(src[5]),
        .can_warn(src[7]), .encoder_warn(src[8]), .rs485_warn(src[9]),
        .torque_off_input_a(src[10]), .torque_off_input_b(tob),
        .undervolt_warn(src[11]), .fieldbus2_warn(src[12]),
        .pos_capture_busy(src[13]), .ethernet_warn(src[14]),
        .fault_clear_command(fclr), .param_rd_req(req),
        .param_rd_addr(addr), .param_rd_data(rdata), .param_rd_ack(ack),
        .param_rd_err(err), .active_warning_word(act),
        .latched_warning_word(lat));

    wsr_master M (.clock(clock), .param_rd_req(req), .param_rd_addr(addr),
        .param_rd_data(rdata), .param_rd_ack(ack), .param_rd_err(err));

    // Free-running 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task chk(input wsr_pkg::wsr_word_t got, input wsr_pkg::wsr_word_t exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task chk_flag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t flag %b expected %b", $time, got, exp);
        end
    endtask

    // Read through the master, then compare data and error flag
    task rdchk(input wsr_pkg::wsr_addr_t a, input wsr_pkg::wsr_word_t exp,
               input logic experr);
        wsr_pkg::wsr_word_t d;
        logic               e;
        M.rd(a, d, e);
        chk(d, exp);
        chk_flag(e, experr);
    endtask

    // Torque pins pass a two-flop synchroniser, so allow a few cycles
    task settle;
        repeat (5) @(posedge clock);
    endtask

    task close_out;
        $display("Comparisons %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Cuts a hang short well beyond the few hundred cycles of the run
    initial begin
        #100000;
        n_fail++;
        close_out;
    end

    initial begin
        n_fail = 0;
        n_compared = 0;
        src = 16'h0000;
        tob = 1'b0;
        fclr = 1'b0;
        sys_rst = 1'b1;
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        rdchk(`WSR_ADDR_ACTIVE, `WSR_WORD_RESET, 1'b0);
        rdchk(`WSR_ADDR_LATCHED, `WSR_WORD_RESET, 1'b0);
        $display("test reset values done");
        // Walk every bit, including the ones that must stay zero
        held = 16'h0000;
        for (i = 0; i < 16; i++) begin
            src <= 16'h0001 << i;
            settle;
            expw = (16'h0001 << i) & ~`WSR_RSVD_MASK;
            chk(act, expw);
            held = held | (expw & ~`WSR_SELF_CLR_MASK);
            chk(lat, held | expw);
            rdchk(`WSR_ADDR_LATCHED, held | expw, 1'b0);
        end
        src <= 16'h0000;
        tob <= 1'b1;
        settle;
        chk(act, 16'h0400);
        tob <= 1'b0;
        settle;
        rdchk(`WSR_ADDR_ACTIVE, 16'h0000, 1'b0);
        rdchk(`WSR_ADDR_LATCHED, held, 1'b0);
        $display("test bit map and self clear done");
        // Reset in mid-run drops every held bit; sources stay idle so no
        // check sees a live warning across the release
        sys_rst <= 1'b1;
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        chk(lat, `WSR_WORD_RESET);
        rdchk(`WSR_ADDR_ACTIVE, `WSR_WORD_RESET, 1'b0);
        rdchk(`WSR_ADDR_LATCHED, `WSR_WORD_RESET, 1'b0);
        // Hold two warnings again so the fault clear has work to do
        src <= 16'h0003;
        settle;
        src <= 16'h0000;
        settle;
        chk(lat, 16'h0003);
        $display("test mid-run reset done");
        // Clear while a warning is live: the live bit survives
        src <= 16'h0080;
        fclr <= 1'b1;
        @(posedge clock);
        fclr <= 1'b0;
        settle;
        rdchk(`WSR_ADDR_LATCHED, 16'h0080, 1'b0);
        src <= 16'h0000;
        fclr <= 1'b1;
        @(posedge clock);
        fclr <= 1'b0;
        settle;
        rdchk(`WSR_ADDR_LATCHED, 16'h0000, 1'b0);
        rdchk(16'h1c17, 16'h0000, 1'b1);
        $display("test fault clear and unmapped read done");
        close_out;
    end
endmodule
